// ==== hw/pin_cfg_pkg.sv ====
// pin function control: shared offsets, fields, resets and timing
// assumes a 10 MHz core clock and a 16-bit register address
package pin_cfg_pkg;

  // ----------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100; // 10 MHz core clock
  localparam int RST_PULSE_MIN_NS = 2000; // least reset pin high time
  // least time rounds up to whole cycles
  localparam int RST_MIN_CYC =
    (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8; // width of the pulse counter

  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] CFG_ADDR = 16'h0800; // pin configuration
  localparam logic [15:0] MODE_ADDR = 16'h0810; // mode request/state
  localparam logic [15:0] WSTAT_ADDR = 16'h0820; // wake status
  localparam logic [15:0] FSTAT_ADDR = 16'h0824; // fault status
  localparam logic [15:0] WMASK_ADDR = 16'h0830; // wake status mask
  localparam logic [15:0] FMASK_ADDR = 16'h0834; // fault status mask

  // ----------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------
  localparam int CFG_TEST_SEL = 0; // test path / enable remap
  localparam int CFG_WKRQ_IRQ = 8; // wake request as interrupt
  localparam int CFG_REGEN_DIS = 9; // regulator enable off
  localparam int CFG_GENERAL_OUT_ONE_FN = 10; // 2 bits, output function
  localparam int CFG_GENERAL_OUT_ONE_SRC = 14; // 2 bits, pin role
  localparam int CFG_WKRQ_VIO = 19; // wake request on io rail
  localparam int CFG_TEST_EN = 21; // test mode
  localparam int CFG_GENERAL_OUT_TWO_FN = 22; // 2 bits, output function
  localparam int CFG_WAKE_SEL = 30; // 2 bits, wake edge select
  localparam logic [31:0] CFG_RESET = 32'h0000_4000;

  // wake edge select codes
  localparam logic [1:0] WAKE_BOTH = 2'h0;
  localparam logic [1:0] WAKE_RISE = 2'h1;
  localparam logic [1:0] WAKE_FALL = 2'h2;
  localparam logic [1:0] WAKE_OFF = 2'h3;

  // general output one role codes
  localparam logic [1:0] GPO_SRC_OUT = 2'h0;
  localparam logic [1:0] GPO_SRC_IRQ = 2'h1;
  localparam logic [1:0] GPO_SRC_WDIN = 2'h2;

  // output function codes, both general outputs
  localparam logic [1:0] FN_CTRL_IRQ = 2'h0;
  localparam logic [1:0] FN_WD_RST = 2'h1;
  localparam logic [1:0] FN_GLOBAL = 2'h2;
  localparam logic [1:0] FN_BUS_WAKE = 2'h3;

  // ----------------------------------------------------------
  // wake status bits
  // ----------------------------------------------------------
  localparam int WST_W = 4;
  localparam int WS_POWER = 0;
  localparam int WS_BUS = 1;
  localparam int WS_LOCAL = 2;
  localparam int WS_ERR = 3;
  localparam logic [3:0] WSTAT_RESET = 4'h1; // power-on flag set
  localparam logic [3:0] WAKE_SRC = 4'hE; // bus, local, error

  // operating modes, gray along standby-normal-sleep
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_SLEEP = 2'h3
  } mode_t;

endpackage

// ==== hw/reset_pulse_qual.sv ====
// reset pin qualifier: one-cycle pulse after a long enough high pulse
// assumes the pin is already synchronous to the clock
`timescale 1ns/10ps
module reset_pulse_qual #(
  parameter int MIN_CYC = 20,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pin level and qualified pulse
  input wire logic pinLevel,
  output logic porPulse
);

  // ----------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------
  if (MIN_CYC < 1 || MIN_CYC >= (1 << CNT_W) - 1) begin : g_bad
    $error("reset pulse count does not fit its counter");
  end

  logic [CNT_W-1:0] highCntQ; // cycles seen high, saturating
  logic levelQ; // previous pin level
  wire fallEdge = levelQ & ~pinLevel;
  wire longEnough = highCntQ >= CNT_W'(MIN_CYC);
  wire cntFull = &highCntQ;

  // count while high, clear while low; saturation stops wrap
  always_ff @(posedge mclk) begin
    if (reset) begin
      highCntQ <= '0;
      levelQ <= 1'b0;
      porPulse <= 1'b0;
    end else begin
      levelQ <= pinLevel;
      if (!pinLevel) begin
        highCntQ <= '0;
      end else if (!cntFull) begin
        highCntQ <= highCntQ + CNT_W'(1);
      end
      porPulse <= fallEdge & longEnough;
    end
  end

endmodule

// ==== hw/pin_function_config.sv ====
// pin function control: regulator enable, wake edges, reset pin,
// wake request, global interrupt, general outputs, test remap
// assumes synchronous pins and a one-cycle register port
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps

// Function
// - regulator enable on except in sleep
// - configuration bit disables regulator enable
// - wake pin detects both edges by default
// - field selects off, rise, fall, both
// - long reset pulse restores defaults, standby
// - reset in normal/standby keeps outputs on
// - reset in sleep turns outputs on
// - wake request latches low by default
// - interrupt option releases when flags clear
// - io rail option: open drain, gated
// - io rail bit survives sleep entry
// - wake request is OR of unmasked wake source flags; the latch also sets on the power-on flag
// - global interrupt: OR of unmasked wake flags and faults
// - phy test mode turns interrupt pin into enable
// - general out one: irq or output
// - general out one as watchdog input
// - test mode routes general out one input
// - general out two function field
// - test mode: general out two test outputs
// - transceiver supply off in sleep only
module pin_function_config #(
  parameter int FAULT_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [pin_cfg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pin_cfg_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [pin_cfg_pkg::DATA_W-1:0] regRdData,
  // pin inputs
  input wire logic pinResetIn,
  input wire logic wakePinIn,
  input wire logic globalIrqIn,
  input wire logic genOneIn,
  // internal events and levels
  input wire logic busWakeIn,
  input wire logic wakeErrIn,
  input wire logic [FAULT_W-1:0] faultIn,
  input wire logic ctrlIrqIn,
  input wire logic wdTimeoutIn,
  input wire logic ioSupplyOk,
  input wire logic phyRxTestOut,
  input wire logic ctrlTxTestOut,
  // pin outputs
  output logic regEnOut,
  output logic regEnOe,
  output logic wakeReqOut,
  output logic wakeReqOe,
  output logic globalIrqOut,
  output logic globalIrqOe,
  output logic genOneOut,
  output logic genOneOe,
  output logic genTwoOut,
  output logic genTwoOe,
  // internal outputs
  output logic vccOutEn,
  output logic xcvrNormalOut,
  output logic phyTxTestIn,
  output logic ctrlRxTestIn,
  output logic wdKick
);
  import pin_cfg_pkg::*;

  // ----------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------
  if (FAULT_W < 1 || FAULT_W > DATA_W) begin : g_bad
    $error("fault width must lie between 1 and 32");
  end

  // ----------------------------------------------------------
  // decoding functions
  // ----------------------------------------------------------
  // asserted level of a general output for a function code
  function automatic logic gpoFn(input logic [1:0] fn,
      input logic ctrlIrq, input logic wd, input logic irq,
      input logic bw);
    logic r;
    r = 1'b0;
    unique case (fn)
      FN_CTRL_IRQ: r = ctrlIrq;
      FN_WD_RST: r = wd;
      FN_GLOBAL: r = irq;
      FN_BUS_WAKE: r = bw;
    endcase
    return r;
  endfunction

  // does an edge count as a local wake under this select
  function automatic logic edgeHit(input logic [1:0] sel,
      input logic rise, input logic fall);
    logic r;
    r = 1'b0;
    unique case (sel)
      WAKE_BOTH: r = rise | fall;
      WAKE_RISE: r = rise;
      WAKE_FALL: r = fall;
      WAKE_OFF: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [31:0] cfgQ, cfgD; // pin configuration
  mode_t modeQ, modeD; // operating mode
  logic [WST_W-1:0] wstatQ, wstatD; // sticky wake flags
  logic [WST_W-1:0] wmaskQ; // 1 masks a wake flag
  logic [FAULT_W-1:0] fstatQ, fstatD; // sticky fault flags
  logic [FAULT_W-1:0] fmaskQ; // 1 masks a fault flag
  logic wakeLatchQ; // latched wake request
  logic wakePrevQ; // previous wake pin sample
  logic genOnePrevQ; // previous general in sample
  logic porPulse; // qualified reset pin pulse

  // ----------------------------------------------------------
  // reset pin qualifier
  // ----------------------------------------------------------
  reset_pulse_qual #(
    .MIN_CYC(RST_MIN_CYC),
    .CNT_W(RST_CNT_W)
  ) u_rst_qual (
    .mclk(mclk),
    .reset(reset),
    .pinLevel(pinResetIn),
    .porPulse(porPulse)
  );

  // ----------------------------------------------------------
  // register decode
  // ----------------------------------------------------------
  // the serial port is unpowered in sleep, so writes drop there
  wire spiOn = modeQ != MODE_SLEEP;
  wire wrEn = regWrite & spiOn;
  wire wrCfg = wrEn & (regAddr == CFG_ADDR);
  wire wrMode = wrEn & (regAddr == MODE_ADDR);
  wire wrWstat = wrEn & (regAddr == WSTAT_ADDR);
  wire wrFstat = wrEn & (regAddr == FSTAT_ADDR);
  wire wrWmask = wrEn & (regAddr == WMASK_ADDR);
  wire wrFmask = wrEn & (regAddr == FMASK_ADDR);
  wire [1:0] modeReq = regWrData[1:0];
  // code 2 is no mode; such a write is ignored
  wire modeReqOk = modeReq != 2'h2;

  // unmapped addresses read as zero
  wire [DATA_W-1:0] rdMux =
    (regAddr == CFG_ADDR) ? cfgQ :
    (regAddr == MODE_ADDR) ? {30'h0, modeQ} :
    (regAddr == WSTAT_ADDR) ? {28'h0, wstatQ} :
    (regAddr == FSTAT_ADDR) ? DATA_W'(fstatQ) :
    (regAddr == WMASK_ADDR) ? {28'h0, wmaskQ} :
    (regAddr == FMASK_ADDR) ? DATA_W'(fmaskQ) : '0;

  // ----------------------------------------------------------
  // local wake detection
  // ----------------------------------------------------------
  wire wakeRise = wakePinIn & ~wakePrevQ;
  wire wakeFall = ~wakePinIn & wakePrevQ;
  wire [1:0] wakeSel = cfgQ[CFG_WAKE_SEL +: 2];
  // wake monitor is off in normal mode
  wire localWake = (modeQ != MODE_NORMAL) &
    edgeHit(wakeSel, wakeRise, wakeFall);

  // ----------------------------------------------------------
  // status flags, set wins over a clear in the same cycle
  // ----------------------------------------------------------
  wire [WST_W-1:0] wakeSet = {wakeErrIn, localWake, busWakeIn, 1'b0};
  wire [WST_W-1:0] wClr = wrWstat ? regWrData[WST_W-1:0] : '0;
  wire [FAULT_W-1:0] fClr = wrFstat ? regWrData[FAULT_W-1:0] : '0;
  assign wstatD = (wstatQ & ~wClr) | wakeSet;
  assign fstatD = (fstatQ & ~fClr) | faultIn;

  // OR of the unmasked wake sources
  wire wakeAny = |(wstatQ & ~wmaskQ & WAKE_SRC);
  wire anyIrq = |(wstatQ & ~wmaskQ) | |(fstatQ & ~fmaskQ);

  // ----------------------------------------------------------
  // mode and configuration next state
  // ----------------------------------------------------------
  // a wake in sleep beats any register request
  always_comb begin
    modeD = modeQ;
    if (modeQ == MODE_SLEEP) begin
      if (localWake | busWakeIn) begin
        modeD = MODE_STANDBY;
      end
    end else if (wrMode & modeReqOk) begin
      modeD = mode_t'(modeReq);
    end
  end

  wire sleepEntry = (modeQ != MODE_SLEEP) & (modeD == MODE_SLEEP);
  wire [31:0] vioKeep = 32'h1 << CFG_WKRQ_VIO;

  // sleep drops settings, except the wake request rail select
  always_comb begin
    cfgD = wrCfg ? regWrData : cfgQ;
    if (sleepEntry) begin
      cfgD = (CFG_RESET & ~vioKeep) | (cfgQ & vioKeep);
    end
  end

  // ----------------------------------------------------------
  // configuration state, cleared by reset or reset pin
  // ----------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || porPulse) begin
      cfgQ <= CFG_RESET;
      modeQ <= MODE_STANDBY;
      wstatQ <= WSTAT_RESET;
      fstatQ <= '0;
      wmaskQ <= '0;
      fmaskQ <= '0;
    end else begin
      cfgQ <= cfgD;
      modeQ <= modeD;
      wstatQ <= wstatD;
      fstatQ <= fstatD;
      if (wrWmask) begin
        wmaskQ <= regWrData[WST_W-1:0];
      end
      if (wrFmask) begin
        fmaskQ <= regWrData[FAULT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------
  // wake request latch
  // ----------------------------------------------------------
  // the reset pin sets it again at once, so an active latch never
  // drops across a reset pin pulse; sleep entry releases it unless wakeAny or the power-on flag sets it
  always_ff @(posedge mclk) begin
    if (reset || porPulse) begin
      wakeLatchQ <= 1'b1;
    end else if (wakeAny | wstatQ[WS_POWER]) begin
      wakeLatchQ <= 1'b1;
    end else if (sleepEntry) begin
      wakeLatchQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // pin output decode
  // ----------------------------------------------------------
  wire testMode = cfgQ[CFG_TEST_EN];
  wire testPhy = testMode & ~cfgQ[CFG_TEST_SEL];
  wire testCtrl = testMode & cfgQ[CFG_TEST_SEL];
  wire notSleep = modeQ != MODE_SLEEP;

  wire regEnOeD = notSleep & ~cfgQ[CFG_REGEN_DIS];
  // interrupt option follows the flags, default holds the latch
  wire wkAssert = cfgQ[CFG_WKRQ_IRQ] ? wakeAny : wakeLatchQ;
  wire onVio = cfgQ[CFG_WKRQ_VIO];
  // io rail: open drain, silent until the rail is stable
  wire wakeReqOutD = onVio ? 1'b0 : ~wkAssert;
  wire wakeReqOeD = onVio ? (wkAssert & ioSupplyOk) : 1'b1;
  // interrupt pin turns input while the phy is under test
  wire globalIrqOeD = ~testPhy & anyIrq;

  wire [1:0] oneSrc = cfgQ[CFG_GENERAL_OUT_ONE_SRC +: 2];
  wire oneFn = gpoFn(cfgQ[CFG_GENERAL_OUT_ONE_FN +: 2], ctrlIrqIn,
    wdTimeoutIn, anyIrq, wstatQ[WS_BUS]);
  wire oneIsIn = testMode | (oneSrc == GPO_SRC_WDIN);
  wire genOneOutD = (oneSrc == GPO_SRC_OUT) ? ~oneFn :
    ~ctrlIrqIn;
  wire wdKickD = ~testMode & (oneSrc == GPO_SRC_WDIN) &
    genOneIn & ~genOnePrevQ;

  wire twoFn = gpoFn(cfgQ[CFG_GENERAL_OUT_TWO_FN +: 2], ctrlIrqIn,
    wdTimeoutIn, anyIrq, wstatQ[WS_BUS]);
  wire twoTest = testPhy ? phyRxTestOut : ctrlTxTestOut;
  // open drain: a low level is driven, a high one released
  wire genTwoOeD = testMode ? ~twoTest : twoFn;

  // ----------------------------------------------------------
  // output registers
  // ----------------------------------------------------------
  // every pin comes from a flop so no decode glitch reaches it
  always_ff @(posedge mclk) begin
    if (reset) begin
      regEnOut <= 1'b1;
      regEnOe <= 1'b1;
      wakeReqOut <= 1'b0;
      wakeReqOe <= 1'b1;
      globalIrqOut <= 1'b0;
      globalIrqOe <= 1'b0;
      genOneOut <= 1'b1;
      genOneOe <= 1'b1;
      genTwoOut <= 1'b0;
      genTwoOe <= 1'b0;
      vccOutEn <= 1'b1;
      xcvrNormalOut <= 1'b0;
      phyTxTestIn <= 1'b1;
      ctrlRxTestIn <= 1'b1;
      wdKick <= 1'b0;
      // load the pin level so the first cycle after reset is no edge
      wakePrevQ <= wakePinIn;
      genOnePrevQ <= genOneIn;
      regRdData <= '0;
    end else begin
      regEnOut <= 1'b1;
      regEnOe <= regEnOeD;
      wakeReqOut <= wakeReqOutD;
      wakeReqOe <= wakeReqOeD;
      globalIrqOut <= 1'b0;
      globalIrqOe <= globalIrqOeD;
      genOneOut <= genOneOutD;
      genOneOe <= ~oneIsIn;
      genTwoOut <= 1'b0;
      genTwoOe <= genTwoOeD;
      vccOutEn <= notSleep;
      // the enable input holds its last level outside test
      if (testPhy) begin
        xcvrNormalOut <= globalIrqIn;
      end
      phyTxTestIn <= testPhy ? genOneIn : 1'b1;
      ctrlRxTestIn <= testCtrl ? genOneIn : 1'b1;
      wdKick <= wdKickD;
      wakePrevQ <= wakePinIn;
      genOnePrevQ <= genOneIn;
      // data stands only in the cycle after the read
      regRdData <= (regRead & spiOn) ? rdMux : '0;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_regen_sleep_off: assert property (
    modeQ == MODE_SLEEP |=> !regEnOe && !vccOutEn)
    else $error("regulator enable driven in sleep");
  a_regen_disable: assert property (
    cfgQ[CFG_REGEN_DIS] |=> !regEnOe)
    else $error("regulator enable driven while disabled");
  a_wake_both: assert property (
    wakeSel == WAKE_BOTH && modeQ != MODE_NORMAL && !porPulse
    && (wakeRise || wakeFall) |=> wstatQ[WS_LOCAL])
    else $error("wake edge missed in both-edge mode");
  a_wake_off: assert property (
    wakeSel == WAKE_OFF && !wakeErrIn && !wstatQ[WS_LOCAL]
    |=> !wstatQ[WS_LOCAL])
    else $error("local wake flagged while detection off");
  a_por_defaults: assert property (
    porPulse |=> modeQ == MODE_STANDBY && cfgQ == CFG_RESET)
    else $error("reset pin did not restore defaults");
  a_por_hold_on: assert property (
    porPulse && notSleep && regEnOe && !cfgQ[CFG_REGEN_DIS]
    |=> regEnOe [*3])
    else $error("regulator enable toggled on reset pin");
  a_por_sleep_on: assert property (
    porPulse && modeQ == MODE_SLEEP |=> ##1 regEnOe && vccOutEn)
    else $error("reset pin in sleep did not turn outputs on");
  a_wkrq_release: assert property (
    cfgQ[CFG_WKRQ_IRQ] && !onVio && !wakeAny |=> wakeReqOut)
    else $error("wake request held with flags clear");
  a_wkrq_vio_gate: assert property (
    onVio && !ioSupplyOk |=> !wakeReqOe)
    else $error("wake request asserted before io rail");
  a_vio_retain: assert property (
    sleepEntry && onVio && !porPulse |=> cfgQ[CFG_WKRQ_VIO])
    else $error("rail select lost on sleep entry");
  a_irq_or: assert property (
    anyIrq && !testPhy |=> globalIrqOe && !globalIrqOut)
    else $error("unmasked flag not shown on interrupt pin");
  a_test_enable: assert property (
    testPhy |=> !globalIrqOe && xcvrNormalOut == $past(globalIrqIn))
    else $error("test enable input not followed");

  c_sleep_wake: cover property (
    modeQ == MODE_SLEEP ##1 modeQ == MODE_STANDBY);
  c_por_pulse: cover property (porPulse);
  c_wd_kick: cover property (wdKick);
  c_test_phy: cover property (testPhy ##1 globalIrqIn);

endmodule

// ==== bench/host_pins.sv ====
// host-side pin model: pull-ups, shared pins and reset pulses
// assumes the core clock of the block paces the host
`timescale 1ns/10ps
module host_pins (
  // clock
  input wire logic mclk,
  // block pins seen by the host
  input wire logic regEnOe,
  input wire logic wakeReqOut,
  input wire logic globalIrqOe,
  input wire logic genOneOut,
  input wire logic genOneOe,
  // host drive levels
  input wire logic enDrive,
  input wire logic oneDrive,
  // resolved pins back into the block
  output logic pinResetIn,
  output wire logic globalIrqIn,
  output wire logic genOneIn
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  // open drain with pull-up; the host may pull low as well
  assign globalIrqIn = globalIrqOe ? 1'b0 : enDrive;
  // host drives the pin only while the block listens
  assign genOneIn = genOneOe ? genOneOut : oneDrive;
  initial pinResetIn = 1'b0; // weak pull-down
  // ----------------------------------------
  // reset pulse, then the settle wait
  // ----------------------------------------
  // bad flags a drop of regEnOe or a release of wakeReqOut during the pulse and the 10 cycles after it
  task automatic pulse_reset(input int n, output logic bad);
    bad = 1'b0;
    @(posedge mclk);
    pinResetIn <= 1'b1;
    for (int i = 0; i < n + 10; i++) begin
      @(posedge mclk);
      if (i == n) pinResetIn <= 1'b0;
      if (regEnOe !== 1'b1 || wakeReqOut !== 1'b0) bad = 1'b1;
    end
    // no register access until the block has settled again
    repeat (7000) @(posedge mclk);
  endtask
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the pin function block
// assumes host_pins resolves the shared pins and pulses reset
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, s); miscompares++; end end
module tb;
  import pin_cfg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [15:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData, d;
  logic wakePinIn = 1'b0, busWakeIn = 1'b0, wakeErrIn = 1'b0;
  logic ctrlIrqIn = 1'b0, wdTimeoutIn = 1'b0, ioSupplyOk = 1'b1;
  logic phyRxTestOut = 1'b1, ctrlTxTestOut = 1'b1;
  logic enDrive = 1'b1, oneDrive = 1'b1, bad, x;
  logic [7:0] faultIn = '0, f;
  logic pinResetIn, globalIrqIn, genOneIn, regEnOut, regEnOe;
  logic wakeReqOut, wakeReqOe, globalIrqOut, globalIrqOe, genOneOut;
  logic genOneOe, genTwoOut, genTwoOe, vccOutEn, xcvrNormalOut;
  logic phyTxTestIn, ctrlRxTestIn, wdKick;
  int miscompares = 0, tests_run = 0, cnt;
  integer seed = 32'hbcfe;
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  pin_function_config i_dut (.mclk, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .pinResetIn, .wakePinIn,
    .globalIrqIn, .genOneIn, .busWakeIn, .wakeErrIn, .faultIn,
    .ctrlIrqIn, .wdTimeoutIn, .ioSupplyOk, .phyRxTestOut,
    .ctrlTxTestOut, .regEnOut, .regEnOe, .wakeReqOut, .wakeReqOe,
    .globalIrqOut, .globalIrqOe, .genOneOut, .genOneOe, .genTwoOut,
    .genTwoOe, .vccOutEn, .xcvrNormalOut, .phyTxTestIn, .ctrlRxTestIn,
    .wdKick);
  host_pins i_host (.mclk, .regEnOe, .wakeReqOut, .globalIrqOe,
    .genOneOut, .genOneOe, .enDrive, .oneDrive, .pinResetIn,
    .globalIrqIn, .genOneIn);
  // 10 MHz core clock
  initial forever #50 mclk = ~mclk;
  // ----------------------------------------
  // bus tasks and helpers
  // ----------------------------------------
  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  // pins follow state one edge after a write lands
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // expected active-low level of a general output function
  function automatic logic fn_level(input logic [1:0] c,
      input logic ci, input logic wd);
    case (c)
      FN_CTRL_IRQ: return !ci;
      FN_WD_RST: return !wd;
      default: return 1'b0; // global and bus wake both pending
    endcase
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, far beyond the two reset settle waits
  initial begin
    #5000000;
    miscompares++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    settle;
    rd(CFG_ADDR, d);
    `CHK("cfg", CFG_RESET, d)
    `CHK("regEnOe", 1'b1, regEnOe)
    `CHK("vccOutEn", 1'b1, vccOutEn)
    `CHK("wakeReq", 1'b0, wakeReqOut)
    `CHK("irqOe", 1'b1, globalIrqOe)
    `CHK("regEnOut", 1'b1, regEnOut)
    `CHK("irqOut", 1'b0, globalIrqOut)
    `CHK("genTwoOut", 1'b0, genTwoOut)
    @(posedge mclk);
    ctrlIrqIn <= 1'b1;
    settle;
    `CHK("genOne", 1'b0, genOneOut)
    wr(WSTAT_ADDR, 32'hF);
    settle;
    `CHK("wakeReq", 1'b0, wakeReqOut)
    `CHK("irqOe", 1'b0, globalIrqOe)
    wr(CFG_ADDR, CFG_RESET | 32'h200);
    settle;
    `CHK("regEnOe", 1'b0, regEnOe)
    // random faults under random masks, first pass unmasked
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h0 : $random(seed);
      f = $random(seed);
      wr(FMASK_ADDR, d);
      @(posedge mclk);
      faultIn <= f;
      @(posedge mclk);
      faultIn <= '0;
      settle;
      `CHK("irqOe", |(f & ~d[7:0]), globalIrqOe)
      wr(FSTAT_ADDR, 32'hFF);
    end
    // every edge select against a rise and a fall, irq style
    for (int c = 0; c < 4; c++) begin
      for (int e = 1; e >= 0; e--) begin
        wr(CFG_ADDR, CFG_RESET | (32'(c) << CFG_WAKE_SEL) | 32'h100);
        wr(WSTAT_ADDR, 32'hF);
        @(posedge mclk);
        wakePinIn <= e[0];
        settle;
        x = (c == WAKE_BOTH) || (c == (e ? WAKE_RISE : WAKE_FALL));
        rd(WSTAT_ADDR, d);
        `CHK("local", x, d[WS_LOCAL])
        `CHK("wakeReq", !x, wakeReqOut)
      end
    end
    // both edges again, irq style, so the masked flag can be set
    wr(CFG_ADDR, CFG_RESET | 32'h100);
    wr(WMASK_ADDR, 32'h4);
    wr(WSTAT_ADDR, 32'hF);
    @(posedge mclk);
    wakePinIn <= 1'b1;
    settle;
    `CHK("wakeReq", 1'b1, wakeReqOut)
    wr(WMASK_ADDR, 32'h0);
    settle;
    `CHK("wakeReq", 1'b0, wakeReqOut)
    // general output functions with the bus wake flag pending
    wr(WSTAT_ADDR, 32'hF);
    @(posedge mclk);
    busWakeIn <= 1'b1;
    @(posedge mclk);
    busWakeIn <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      ctrlIrqIn <= $random(seed);
      wdTimeoutIn <= $random(seed);
      wr(CFG_ADDR, (32'(c) << CFG_GENERAL_OUT_ONE_FN) | (32'(c) << CFG_GENERAL_OUT_TWO_FN));
      settle;
      x = fn_level(c[1:0], ctrlIrqIn, wdTimeoutIn);
      `CHK("genOne", x, genOneOut)
      `CHK("genTwoOe", !x, genTwoOe)
    end
    // watchdog kick through general out one as an input
    wr(CFG_ADDR, 32'(GPO_SRC_WDIN) << CFG_GENERAL_OUT_ONE_SRC);
    @(posedge mclk);
    oneDrive <= 1'b0;
    settle;
    cnt = 0;
    @(posedge mclk);
    oneDrive <= 1'b1;
    repeat (6) begin
      @(posedge mclk);
      #1 cnt += (wdKick === 1'b1);
    end
    `CHK("genOneOe", 1'b0, genOneOe)
    `CHK("kick", 1'b1, cnt != 0)
    // test remap, phy path then controller path
    for (int i = 0; i < 8; i++) begin
      wr(CFG_ADDR, 32'h20_0000 | 32'(i >= 4));
      @(posedge mclk);
      enDrive <= $random(seed);
      oneDrive <= $random(seed);
      phyRxTestOut <= $random(seed);
      ctrlTxTestOut <= $random(seed);
      settle;
      if (i < 4) begin
        `CHK("normal", enDrive, xcvrNormalOut)
        `CHK("phyTx", oneDrive, phyTxTestIn)
        `CHK("genTwoOe", !phyRxTestOut, genTwoOe)
      end else begin
        `CHK("ctrlRx", oneDrive, ctrlRxTestIn)
        `CHK("genTwoOe", !ctrlTxTestOut, genTwoOe)
      end
    end
    @(posedge mclk);
    enDrive <= 1'b1;
    oneDrive <= 1'b1;
    ioSupplyOk <= 1'b0;
    // sleep with the io rail option, then a local wake
    wr(CFG_ADDR, CFG_RESET | 32'h8_0000);
    wr(MODE_ADDR, 32'(MODE_SLEEP));
    settle;
    `CHK("regEnOe", 1'b0, regEnOe)
    `CHK("vccOutEn", 1'b0, vccOutEn)
    rd(CFG_ADDR, d);
    `CHK("sleepRd", 32'h0, d)
    @(posedge mclk);
    wakePinIn <= 1'b0;
    settle;
    `CHK("regEnOe", 1'b1, regEnOe)
    `CHK("vccOutEn", 1'b1, vccOutEn)
    rd(CFG_ADDR, d);
    `CHK("ioRail", 1'b1, d[CFG_WKRQ_VIO])
    `CHK("wakeReqOe", 1'b0, wakeReqOe)
    @(posedge mclk);
    ioSupplyOk <= 1'b1;
    settle;
    `CHK("wakeReqOe", 1'b1, wakeReqOe)
    // pin reset from sleep, then from standby
    wr(MODE_ADDR, 32'(MODE_SLEEP));
    settle;
    i_host.pulse_reset(25, bad);
    `CHK("regEnOe", 1'b1, regEnOe)
    `CHK("wakeReq", 1'b0, wakeReqOut)
    rd(CFG_ADDR, d);
    `CHK("cfg", CFG_RESET, d)
    rd(MODE_ADDR, d);
    `CHK("mode", MODE_STANDBY, d[1:0])
    i_host.pulse_reset(25, bad);
    `CHK("toggle", 1'b0, bad)
    rd(16'h0FF0, d);
    `CHK("unmapped", 32'h0, d)
    report_and_stop();
  end
endmodule
